/* File: testbench/fswp_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

module fswp_host_model (
   // Clock
   input wire logic clock_in,
   // Serial status from device
   input wire logic so_in,
   input wire logic so_oe_in,
   // Link pins and read request
   output logic sck_out,
   output logic cs_n_out,
   output logic read_start_out
);
   logic so_last_q;
   logic so_wire;

   always @(posedge clock_in) begin
      if (so_oe_in) begin
         so_last_q <= so_in;
      end
   end
   // Released line shows the inverse of the last bit
   assign so_wire = so_oe_in ? so_in : ~so_last_q;

   initial begin
      so_last_q = 1'b0;
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      read_start_out = 1'b0;
   end

   task automatic read_status(input int nbytes, output logic [15:0] seen, output logic oe_ok);
      seen = 16'h0000;
      oe_ok = 1'b1;
      cs_n_out <= 1'b0;
      repeat (6) @(posedge clock_in);
      read_start_out <= 1'b1;
      @(posedge clock_in);
      read_start_out <= 1'b0;
      repeat (4) @(posedge clock_in);
      // Link clock of 16 core cycles, changed on core edges
      for (int i = 0; i < nbytes * 8; i++) begin
         sck_out <= 1'b1;
         seen = {seen[14:0], so_wire};
         oe_ok = oe_ok & so_oe_in;
         repeat (8) @(posedge clock_in);
         sck_out <= 1'b0;
         repeat (8) @(posedge clock_in);
      end
      cs_n_out <= 1'b1;
      repeat (6) @(posedge clock_in);
   endtask : read_status
endmodule : fswp_host_model

`default_nettype wire

/* File: testbench/tb_fswp_status_protect.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_fswp_status_protect;
   import fswp_pkg::*;

   logic clock_in;
   logic rst_in;
   logic wp_n;
   logic sck;
   logic cs_n;
   logic cmd_valid;
   fswp_cmd_t cmd;
   logic op_done;
   logic aai_end;
   logic read_start;
   logic read_sel;
   logic exec;
   logic reject;
   fswp_status_main_t st_main;
   fswp_status_sector_t st_sec;
   logic so;
   logic so_oe;
   int err_count;
   int cmp_count;
   int cycles;
   logic [31:0] seed_ret;
   logic [1:0] bp;
   logic top;
   logic bot;
   logic ok;
   logic [17:0] a;
   logic [17:0] lo;
   logic [17:0] hi;
   int kind;
   fswp_op_t ops [4] = '{FSWP_OP_BYTE_PROG, FSWP_OP_SECTOR_ERASE, FSWP_OP_BLOCK_ERASE,
      FSWP_OP_CHIP_ERASE};
   logic [17:0] corner [6] = '{18'h3f000, 18'h00fff, 18'h2ffff, 18'h30000, 18'h1ffff, 18'h01000};

   fswp_status_protect dut (.clock_in(clock_in), .rst_in(rst_in), .wp_n_in(wp_n), .sck_in(sck),
      .cs_n_in(cs_n), .cmd_valid_in(cmd_valid), .cmd_in(cmd), .op_done_in(op_done),
      .aai_end_in(aai_end), .read_start_in(read_start), .read_sel_in(read_sel),
      .exec_out(exec), .reject_out(reject), .status_main_out(st_main),
      .status_sector_out(st_sec), .so_out(so), .so_oe_out(so_oe));

   fswp_host_model host (.clock_in(clock_in), .so_in(so), .so_oe_in(so_oe), .sck_out(sck),
      .cs_n_out(cs_n), .read_start_out(read_start));

   initial begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         finish_test();
      end
   end

   task automatic do_cmd(input fswp_op_t op, input logic [17:0] lo_a, input logic [17:0] hi_a,
         input logic [7:0] mb, input logic [7:0] sb, input logic exp);
      @(posedge clock_in);
      cmd_valid <= 1'b1;
      cmd <= '{op: op, addr_lo: lo_a, addr_hi: hi_a, main_byte: mb, sector_byte: sb,
         two_bytes: 1'b1};
      @(posedge clock_in);
      cmd_valid <= 1'b0;
      #1;
      check({6'h00, exec, reject}, {6'h00, exp, ~exp});
      @(posedge clock_in);
      #1;
   endtask : do_cmd

   task automatic pulse(input logic done);
      @(posedge clock_in);
      if (done) op_done <= 1'b1;
      else aai_end <= 1'b1;
      @(posedge clock_in);
      op_done <= 1'b0;
      aai_end <= 1'b0;
      repeat (2) @(posedge clock_in);
      #1;
   endtask : pulse

   task automatic set_wp(input logic level);
      @(posedge clock_in);
      wp_n <= level;
      repeat (4) @(posedge clock_in);
   endtask : set_wp

   task automatic read_check(input logic sel, input logic [7:0] exp);
      logic [15:0] seen;
      logic oe_ok;
      @(posedge clock_in);
      read_sel <= sel;
      host.read_status(2, seen, oe_ok);
      check(seen[15:8], exp);
      check(seen[7:0], exp);
      check({7'h00, oe_ok}, 8'h01);
   endtask : read_check

   task automatic set_status(input logic [7:0] mb, input logic [7:0] sb);
      do_cmd(FSWP_OP_WRITE_ENABLE_COMMAND, 18'h0, 18'h0, 8'h00, 8'h00, 1'b1);
      do_cmd(FSWP_OP_STATUS_WRITE_COMMAND, 18'h0, 18'h0, mb, sb, 1'b1);
   endtask : set_status

   function automatic logic exp_ok(input logic [1:0] b, input logic t, input logic l,
         input logic [17:0] lo_a, input logic [17:0] hi_a);
      logic [17:0] plo;
      plo = (b == 2'b01) ? 18'h30000 : (b == 2'b10) ? 18'h20000 : 18'h00000;
      exp_ok = 1'b1;
      if (b != 2'b00 && hi_a >= plo) exp_ok = 1'b0;
      if (t && hi_a >= 18'h3f000) exp_ok = 1'b0;
      if (l && lo_a <= 18'h00fff) exp_ok = 1'b0;
   endfunction : exp_ok

   initial begin
      rst_in = 1'b1;
      wp_n = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
      op_done = 1'b0;
      aai_end = 1'b0;
      read_sel = 1'b0;
      err_count = 0;
      cmp_count = 0;
      cycles = 0;
      seed_ret = $urandom(32'h40a13758);
      repeat (16) @(posedge clock_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      #1;
      check(st_main, 8'h0c);
      check(st_sec, 8'h00);
      read_check(1'b0, 8'h0c);
      read_check(1'b1, 8'h00);
      do_cmd(FSWP_OP_BYTE_PROG, 18'h01000, 18'h01000, 8'h00, 8'h00, 1'b0);
      do_cmd(FSWP_OP_WRITE_ENABLE_COMMAND, 18'h0, 18'h0, 8'h00, 8'h00, 1'b1);
      do_cmd(FSWP_OP_BYTE_PROG, 18'h00010, 18'h00010, 8'h00, 8'h00, 1'b0);
      do_cmd(FSWP_OP_STATUS_WRITE_COMMAND, 18'h0, 18'h0, 8'hf3, 8'hff, 1'b1);
      check(st_main, 8'h80);
      check(st_sec, 8'h0c);
      set_wp(1'b0);
      do_cmd(FSWP_OP_STATUS_WRITE_COMMAND, 18'h0, 18'h0, 8'h0c, 8'h00, 1'b0);
      check(st_main, 8'h80);
      check(st_sec, 8'h0c);
      set_wp(1'b1);
      set_status(8'h00, 8'h00);
      check(st_main, 8'h00);
      set_wp(1'b0);
      set_status(8'h04, 8'h04);
      check(st_main, 8'h04);
      check(st_sec, 8'h04);
      set_wp(1'b1);
      for (int n = 0; n < 24; n++) begin
         bp = (n < 4) ? 2'(n) : 2'($urandom_range(3));
         top = 1'($urandom_range(1));
         bot = 1'($urandom_range(1));
         a = (n < 6) ? corner[n] : 18'($urandom);
         kind = (n < 4) ? n : $urandom_range(3);
         set_status({4'h0, bp, 2'b00}, {4'h0, bot, top, 2'b00});
         lo = (kind == 0) ? a : (kind == 1) ? {a[17:12], 12'h000} : (kind == 2) ?
            {a[17:16], 16'h0000} : 18'h00000;
         hi = (kind == 0) ? a : (kind == 1) ? {a[17:12], 12'hfff} : (kind == 2) ?
            {a[17:16], 16'hffff} : 18'h3ffff;
         ok = exp_ok(bp, top, bot, lo, hi);
         do_cmd(FSWP_OP_WRITE_ENABLE_COMMAND, 18'h0, 18'h0, 8'h00, 8'h00, 1'b1);
         do_cmd(ops[kind], lo, hi, 8'h00, 8'h00, ok);
         if (ok) begin
            check({7'h00, st_main.busy}, 8'h01);
            read_check(1'b0, {4'h0, bp, 2'b11});
            pulse(1'b1);
            check(st_main, {4'h0, bp, 2'b00});
         end else begin
            check(st_main, {4'h0, bp, 2'b10});
            do_cmd(FSWP_OP_WRITE_DISABLE_COMMAND, 18'h0, 18'h0, 8'h00, 8'h00, 1'b1);
            check(st_main, {4'h0, bp, 2'b00});
         end
         read_check(1'b1, {4'h0, bot, top, 2'b00});
      end
      set_status(8'h00, 8'h00);
      do_cmd(FSWP_OP_WRITE_ENABLE_COMMAND, 18'h0, 18'h0, 8'h00, 8'h00, 1'b1);
      do_cmd(FSWP_OP_AAI_START, 18'h10000, 18'h10001, 8'h00, 8'h00, 1'b1);
      check({7'h00, st_main.auto_increment_program_mode}, 8'h01);
      pulse(1'b1);
      do_cmd(FSWP_OP_WRITE_ENABLE_COMMAND, 18'h0, 18'h0, 8'h00, 8'h00, 1'b0);
      do_cmd(FSWP_OP_AAI_WORD, 18'h10002, 18'h10003, 8'h00, 8'h00, 1'b1);
      check({7'h00, st_main.busy}, 8'h01);
      pulse(1'b1);
      check(st_main, 8'h42);
      pulse(1'b0);
      check(st_main, 8'h00);
      set_status(8'h84, 8'h0c);
      do_cmd(FSWP_OP_WRITE_ENABLE_COMMAND, 18'h0, 18'h0, 8'h00, 8'h00, 1'b1);
      check(st_main, 8'h86);
      check(st_sec, 8'h0c);
      // Second reset in mid-run
      @(posedge clock_in);
      rst_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      #1;
      check(st_main, 8'h0c);
      check(st_sec, 8'h00);
      read_check(1'b0, 8'h0c);
      finish_test();
   end
endmodule : tb_fswp_status_protect

`default_nettype wire

/* File: verilog/fswp_map.svh */
`ifndef FSWP_MAP_SVH
`define FSWP_MAP_SVH

// Array geometry
`define FSWP_ADDR_W 18
`define FSWP_ADDR_FIRST 18'h00000
`define FSWP_ADDR_LAST 18'h3ffff
`define FSWP_QUARTER_LO 18'h30000
`define FSWP_HALF_LO 18'h20000
`define FSWP_TOP_SECTOR_LO 18'h3f000
`define FSWP_BOT_SECTOR_HI 18'h00fff

// Block protect codes
`define FSWP_BP_NONE 2'b00
`define FSWP_BP_QUARTER 2'b01
`define FSWP_BP_HALF 2'b10
`define FSWP_BP_FULL 2'b11

// Power-up values
`define FSWP_RST_BUSY 1'b0
`define FSWP_RST_WEL 1'b0
`define FSWP_RST_AAI 1'b0
`define FSWP_RST_BP 2'b11
`define FSWP_RST_LOCK 1'b0
`define FSWP_RST_TOP 1'b0
`define FSWP_RST_BOT 1'b0
`define FSWP_RSV_MAIN 2'h0
`define FSWP_RSV_LO 2'h0
`define FSWP_RSV_HI 4'h0

// Status shift-out
`define FSWP_LAST_BIT 3'h7

`endif

/* File: verilog/fswp_pkg.sv */
`include "fswp_map.svh"

package fswp_pkg;

   typedef enum logic [3:0] {
      FSWP_OP_NOP,
      FSWP_OP_WRITE_ENABLE_COMMAND,
      FSWP_OP_WRITE_DISABLE_COMMAND,
      FSWP_OP_STATUS_WRITE_COMMAND,
      FSWP_OP_BYTE_PROG,
      FSWP_OP_AAI_START,
      FSWP_OP_AAI_WORD,
      FSWP_OP_SECTOR_ERASE,
      FSWP_OP_BLOCK_ERASE,
      FSWP_OP_CHIP_ERASE
   } fswp_op_t;

   typedef struct packed {
      fswp_op_t op;
      logic [`FSWP_ADDR_W-1:0] addr_lo;
      logic [`FSWP_ADDR_W-1:0] addr_hi;
      logic [7:0] main_byte;
      logic [7:0] sector_byte;
      logic two_bytes;
   } fswp_cmd_t;

   typedef struct packed {
      logic protect_lock_bit;
      logic auto_increment_program_mode;
      logic [1:0] rsv;
      logic block_protect_high;
      logic block_protect_low;
      logic write_enable_latch;
      logic busy;
   } fswp_status_main_t;

   typedef struct packed {
      logic [3:0] rsv_hi;
      logic bottom_sector_lock;
      logic top_sector_lock;
      logic [1:0] rsv_lo;
   } fswp_status_sector_t;

endpackage : fswp_pkg

/* File: verilog/fswp_status_protect.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fswp_map.svh"

// Behaviour
// - Status write refused when protect pin low and lock bit set, or while busy or in auto-increment mode; else executed.
// - Bit 0 reads 1 while busy, read-only, cleared at power-up.
// - Bit 1 is the write enable latch; at 0 program/erase are refused.
// - Latch clears on power-up, disable, program, erase, status write, AUTO_INCREMENT_PROGRAM_MODE end.
// - Bit 6 read-only, 1 in auto-increment mode; single-byte at power-up.
// - Block protect bits at 2 and 3, writable, both 1 at power-up.
// - Code 00 none, 01 top quarter, 10 top half, 11 whole array.
// - No program or erase inside the block-protected range.
// - Whole-chip erase only when both block protect bits are 0.
// - Pin low and lock set freeze lock, block protect and sector locks.
// - Pin high makes lock bit inert; lock bit 0 at power-up.
// - Reserved status bits read 0.
// - Second register bit 2 top lock, bit 3 bottom lock, both 0 at reset.
// - Locked end sector in target range blocks program and all erases.
// - Each sector lock acts alone; at 0 its sector stays writable.
// - End sector locks each cover one 4-Kbyte sector.
module fswp_status_protect (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Pins
   input wire logic wp_n_in,
   input wire logic sck_in,
   input wire logic cs_n_in,
   // Decoded command strobes
   input wire logic cmd_valid_in,
   input wire fswp_pkg::fswp_cmd_t cmd_in,
   input wire logic op_done_in,
   input wire logic aai_end_in,
   // Status read requests
   input wire logic read_start_in,
   input wire logic read_sel_in,
   // Verdicts and status
   output logic exec_out,
   output logic reject_out,
   output var fswp_pkg::fswp_status_main_t status_main_out,
   output var fswp_pkg::fswp_status_sector_t status_sector_out,
   // Serial status out
   output logic so_out,
   output logic so_oe_out
);
   import fswp_pkg::*;

   logic [2:0] pins_s;
   logic wp_n_s;
   logic sck_s;
   logic cs_n_s;

   fswp_sync u_sync (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .async_in({wp_n_in, sck_in, cs_n_in}),
      .sync_out(pins_s)
   );

   assign wp_n_s = pins_s[2];
   assign sck_s = pins_s[1];
   assign cs_n_s = pins_s[0];

   logic busy_q;
   logic wel_q;
   logic aai_q;
   logic [1:0] bp_q;
   logic lock_q;
   logic top_q;
   logic bot_q;
   logic wel_on_done_q;
   logic read_sel_q;

   logic is_array;
   logic [`FSWP_ADDR_W-1:0] eff_lo;
   logic [`FSWP_ADDR_W-1:0] eff_hi;
   logic bp_hit;
   logic top_hit;
   logic bot_hit;
   logic prot_hit;
   logic wsr_ok;
   logic take;
   logic aai_stop;

   function automatic logic overlap(
      input logic [`FSWP_ADDR_W-1:0] lo,
      input logic [`FSWP_ADDR_W-1:0] hi,
      input logic [`FSWP_ADDR_W-1:0] plo
   );
      overlap = (lo <= `FSWP_ADDR_LAST) && (hi >= plo);
   endfunction : overlap

   always_comb begin
      is_array = 1'b0;
      unique case (cmd_in.op)
         FSWP_OP_BYTE_PROG, FSWP_OP_AAI_START, FSWP_OP_AAI_WORD,
         FSWP_OP_SECTOR_ERASE, FSWP_OP_BLOCK_ERASE,
         FSWP_OP_CHIP_ERASE: begin
            is_array = 1'b1;
         end
         FSWP_OP_NOP, FSWP_OP_WRITE_ENABLE_COMMAND, FSWP_OP_WRITE_DISABLE_COMMAND, FSWP_OP_STATUS_WRITE_COMMAND: begin
            is_array = 1'b0;
         end
         default: begin
            is_array = 1'b0;
         end
      endcase
   end

   // Chip erase targets the whole array
   always_comb begin
      eff_lo = cmd_in.addr_lo;
      eff_hi = cmd_in.addr_hi;
      if (cmd_in.op == FSWP_OP_CHIP_ERASE) begin
         eff_lo = `FSWP_ADDR_FIRST;
         eff_hi = `FSWP_ADDR_LAST;
      end
   end

   always_comb begin
      bp_hit = 1'b0;
      unique case (bp_q)
         `FSWP_BP_NONE: begin
            bp_hit = 1'b0;
         end
         `FSWP_BP_QUARTER: begin
            bp_hit = overlap(eff_lo, eff_hi, `FSWP_QUARTER_LO);
         end
         `FSWP_BP_HALF: begin
            bp_hit = overlap(eff_lo, eff_hi, `FSWP_HALF_LO);
         end
         `FSWP_BP_FULL: begin
            bp_hit = 1'b1;
         end
      endcase
   end

   // one 4-Kbyte sector at each end
   // each lock tested on its own
   assign top_hit = top_q && (eff_hi >= `FSWP_TOP_SECTOR_LO);
   assign bot_hit = bot_q && (eff_lo <= `FSWP_BOT_SECTOR_HI);
   assign prot_hit = bp_hit | top_hit | bot_hit;

   // pin high makes the lock bit inert
   assign wsr_ok = wp_n_s | ~lock_q;

   // Acceptance of one decoded command
   always_comb begin
      take = 1'b0;
      unique case (cmd_in.op)
         FSWP_OP_WRITE_ENABLE_COMMAND: begin
            take = ~busy_q & ~aai_q;
         end
         FSWP_OP_WRITE_DISABLE_COMMAND: begin
            take = ~busy_q;
         end
         FSWP_OP_STATUS_WRITE_COMMAND: begin
            take = ~busy_q & ~aai_q & wsr_ok;
         end
         FSWP_OP_AAI_WORD: begin
            take = ~busy_q & wel_q & aai_q & ~prot_hit;
         end
         FSWP_OP_BYTE_PROG, FSWP_OP_AAI_START, FSWP_OP_SECTOR_ERASE,
         FSWP_OP_BLOCK_ERASE, FSWP_OP_CHIP_ERASE: begin
            take = ~busy_q & wel_q & ~aai_q & ~prot_hit;
         end
         FSWP_OP_NOP: begin
            take = 1'b0;
         end
         default: begin
            take = 1'b0;
         end
      endcase
      take = take & cmd_valid_in;
   end

   // AUTO_INCREMENT_PROGRAM_MODE ends at its end strobe, a disable, or a protected word
   assign aai_stop = aai_q & (aai_end_in
      | (cmd_valid_in & (cmd_in.op == FSWP_OP_AAI_WORD) & ~busy_q & prot_hit)
      | (take & (cmd_in.op == FSWP_OP_WRITE_DISABLE_COMMAND)));

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         busy_q <= `FSWP_RST_BUSY;
      end else if (take && is_array) begin
         busy_q <= 1'b1;
      end else if (op_done_in) begin
         busy_q <= 1'b0;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         wel_on_done_q <= 1'b0;
      end else if (take && is_array) begin
         wel_on_done_q <= (cmd_in.op != FSWP_OP_AAI_START) &&
                          (cmd_in.op != FSWP_OP_AAI_WORD);
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         wel_q <= `FSWP_RST_WEL;
      end else if (take && (cmd_in.op == FSWP_OP_WRITE_ENABLE_COMMAND)) begin
         wel_q <= 1'b1;
      end else if ((take && (cmd_in.op == FSWP_OP_WRITE_DISABLE_COMMAND)) ||
                   (take && (cmd_in.op == FSWP_OP_STATUS_WRITE_COMMAND)) ||
                   (op_done_in && busy_q && wel_on_done_q) || aai_stop) begin
         wel_q <= 1'b0;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         aai_q <= `FSWP_RST_AAI;
      end else if (take && (cmd_in.op == FSWP_OP_AAI_START)) begin
         aai_q <= 1'b1;
      end else if (aai_stop) begin
         aai_q <= 1'b0;
      end
   end

   // only protection bits take write data
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         bp_q <= `FSWP_RST_BP;
         lock_q <= `FSWP_RST_LOCK;
         top_q <= `FSWP_RST_TOP;
         bot_q <= `FSWP_RST_BOT;
      end else if (take && (cmd_in.op == FSWP_OP_STATUS_WRITE_COMMAND)) begin
         bp_q <= {cmd_in.main_byte[3], cmd_in.main_byte[2]};
         lock_q <= cmd_in.main_byte[7];
         if (cmd_in.two_bytes) begin
            top_q <= cmd_in.sector_byte[2];
            bot_q <= cmd_in.sector_byte[3];
         end
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         exec_out <= 1'b0;
         reject_out <= 1'b0;
      end else begin
         exec_out <= take;
         reject_out <= cmd_valid_in & ~take & (cmd_in.op != FSWP_OP_NOP);
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         status_main_out <= '0;
         status_sector_out <= '0;
      end else begin
         status_main_out <= '{protect_lock_bit: lock_q,
                              auto_increment_program_mode: aai_q,
                              rsv: `FSWP_RSV_MAIN,
                              block_protect_high: bp_q[1],
                              block_protect_low: bp_q[0],
                              write_enable_latch: wel_q,
                              busy: busy_q};
         status_sector_out <= '{rsv_hi: `FSWP_RSV_HI,
                                bottom_sector_lock: bot_q,
                                top_sector_lock: top_q,
                                rsv_lo: `FSWP_RSV_LO};
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         read_sel_q <= 1'b0;
      end else if (read_start_in) begin
         read_sel_q <= read_sel_in;
      end
   end

   logic load_q;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         load_q <= 1'b0;
      end else begin
         load_q <= read_start_in;
      end
   end

   fswp_status_shift u_shift (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .sck_in(sck_s),
      .cs_n_in(cs_n_s),
      .load_in(load_q),
      .byte_in(read_sel_q ? status_sector_out : status_main_out),
      .so_out(so_out),
      .so_oe_out(so_oe_out)
   );

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);

   AST_STATUS_WRITE_COMMAND_REFUSED: assert property (
      cmd_valid_in && (cmd_in.op == FSWP_OP_STATUS_WRITE_COMMAND) && !wp_n_s && lock_q
      |=> reject_out && !exec_out)
      else $error("status write taken while locked");

   AST_BUSY_SET: assert property (
      take && is_array |=> busy_q ##1 status_main_out.busy)
      else $error("busy not shown after accepted operation");

   AST_NO_LATCH_NO_WRITE: assert property (
      cmd_valid_in && is_array && !wel_q && !busy_q |=> reject_out && !busy_q)
      else $error("array operation accepted without latch");

   AST_STATUS_WRITE_COMMAND_CLEARS_LATCH: assert property (
      take && (cmd_in.op == FSWP_OP_STATUS_WRITE_COMMAND) |=> !wel_q ##1 !status_main_out.write_enable_latch)
      else $error("latch not cleared by status write");

   AST_AAI_SHOWN: assert property (
      status_main_out.auto_increment_program_mode == $past(aai_q))
      else $error("auto-increment bit does not follow mode");

   AST_BP_BLOCKS: assert property (
      cmd_valid_in && is_array && !busy_q && wel_q && bp_hit |=> !exec_out && !busy_q)
      else $error("write into block-protected range");

   AST_CHIP_ERASE_GATE: assert property (
      cmd_valid_in && (cmd_in.op == FSWP_OP_CHIP_ERASE) && (bp_q != `FSWP_BP_NONE)
      |=> !exec_out)
      else $error("chip erase with protection set");

   AST_LOCK_FREEZE: assert property (
      !wsr_ok |=> $stable(bp_q) && $stable(lock_q) && $stable(top_q) && $stable(bot_q))
      else $error("protection bits changed while locked");

   AST_RESERVED_ZERO: assert property (
      status_main_out.rsv == `FSWP_RSV_MAIN && status_sector_out.rsv_lo == `FSWP_RSV_LO
      && status_sector_out.rsv_hi == `FSWP_RSV_HI)
      else $error("reserved status bit set");

   AST_SECTOR_BLOCKS: assert property (
      cmd_valid_in && is_array && (top_hit || bot_hit) |=> !exec_out)
      else $error("write into locked end sector");

   AST_STATUS_WRITE_COMMAND_KEEPS_STATE: assert property (
      take && (cmd_in.op == FSWP_OP_STATUS_WRITE_COMMAND) |=> $stable(busy_q) && $stable(aai_q))
      else $error("status write altered internal bits");

   COV_ARRAY_EXEC: cover property (take && is_array ##1 busy_q);
   COV_STATUS_WRITE_COMMAND_REFUSED: cover property (cmd_valid_in && (cmd_in.op == FSWP_OP_STATUS_WRITE_COMMAND) && !wsr_ok);
   COV_AAI_RUN: cover property ($rose(aai_q));
   COV_STATUS_READ: cover property ($rose(so_oe_out));

endmodule : fswp_status_protect

`default_nettype wire

/* File: verilog/fswp_status_shift.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fswp_map.svh"

module fswp_status_shift (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Synchronised link pins
   input wire logic sck_in,
   input wire logic cs_n_in,
   // Read request and live status byte
   input wire logic load_in,
   input wire logic [7:0] byte_in,
   // Serial out
   output logic so_out,
   output logic so_oe_out
);
   import fswp_pkg::*;

   logic sck_prev_q;
   logic active_q;
   logic [2:0] cnt_q;
   logic [7:0] shreg_q;
   logic fall;

   assign fall = sck_prev_q & ~sck_in;

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         sck_prev_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_in;
      end
   end

   // Repeats the live byte every eight bits so polling sees fresh state
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         active_q <= 1'b0;
         cnt_q <= 3'h0;
         shreg_q <= 8'h00;
         so_out <= 1'b0;
         so_oe_out <= 1'b0;
      end else if (cs_n_in) begin
         active_q <= 1'b0;
         so_oe_out <= 1'b0;
      end else if (load_in) begin
         active_q <= 1'b1;
         so_oe_out <= 1'b1;
         so_out <= byte_in[7];
         shreg_q <= {byte_in[6:0], 1'b0};
         cnt_q <= 3'h0;
      end else if (active_q && fall) begin
         if (cnt_q == `FSWP_LAST_BIT) begin
            so_out <= byte_in[7];
            shreg_q <= {byte_in[6:0], 1'b0};
            cnt_q <= 3'h0;
         end else begin
            so_out <= shreg_q[7];
            shreg_q <= {shreg_q[6:0], 1'b0};
            cnt_q <= cnt_q + 3'h1;
         end
      end
   end

endmodule : fswp_status_shift

`default_nettype wire

/* File: verilog/fswp_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module fswp_sync (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Pin levels
   input wire logic [2:0] async_in,
   output logic [2:0] sync_out
);
   import fswp_pkg::*;

   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1) begin : g_bit
         logic meta_q;
         always_ff @(posedge clock_in or posedge rst_in) begin
            if (rst_in) begin
               meta_q <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               meta_q <= async_in[i];
               sync_out[i] <= meta_q;
            end
         end
      end
   endgenerate

endmodule : fswp_sync

`default_nettype wire
